// File: rtl/apr_bank.sv
/*
 Program register bank: shadowed mode, clock divide, test pattern,
 self-test and offset trim registers, with a transfer register that
 commits the shadows, plus the output pattern / offset datapath.
 Assumes the serial port decoder supplies single-cycle read and write
 strobes on clk, and converter samples arrive on clk.
*/
// What this block does
// - Setting transfer bit 0 copies every shadow register into the active set at once; it reads zero after reset.
// - Writes to 0x08..0x18 do not alter behaviour until 0x01 is written to the transfer register, which then clears itself.
// - The input clock is divided by the divide field plus one, and the field resets to zero.
// - A four-bit test field selects off, midscale, full scales, checkerboard, two PN sequences, toggles, user, sync or one-bit-high.
// - With any nonzero pattern selected, generated test words replace converted samples on the outputs.
// - The eight-bit trim is twos complement and adds +127 to -128 LSB to converted samples, not to test words, zero after reset.
`timescale 1ns/1ps
`default_nettype none
module apr_bank
    import apr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [APR_AW-1:0] reg_addr,
    input  wire logic [APR_DW-1:0] reg_wdata,
    output var  logic [APR_DW-1:0] reg_rdata,
    input  wire logic [APR_SW-1:0] adc_sample,
    input  wire logic [APR_SW-1:0] user_pattern,
    output var  logic [APR_SW-1:0] data_out,
    output var  logic              clk_div_pulse,
    output var  logic [7:0]        modes_active,
    output var  logic              bist_start
);
    // maps a bank address onto a storage slot, 7 means none
    function automatic logic [2:0] slot_of(input logic [7:0] a);
        case (a)
            APR_ADDR_MODES:  slot_of = 3'd0;
            APR_ADDR_CLKDIV: slot_of = 3'd1;
            APR_ADDR_TEST:   slot_of = 3'd2;
            APR_ADDR_BIST:   slot_of = 3'd3;
            APR_ADDR_OFFSET: slot_of = 3'd4;
            default:         slot_of = 3'd7;
        endcase
    endfunction : slot_of

    logic [5*8-1:0] active;
    logic [7:0]     rf_rdata;
    logic           commit_q, commit_d;
    logic           rd_commit_q, rd_commit_d;
    logic [7:0]     wmask;
    logic           shadow_wr;
    logic [7:0]     clkdiv_act, test_act, bist_act, offs_act;
    logic           bist_en_q, bist_en_d;
    logic           bist_start_d;

    always_comb begin
        case (slot_of(reg_addr))
            3'd1:    wmask = APR_CLKDIV_MASK;
            3'd3:    wmask = APR_BIST_MASK;
            default: wmask = 8'hFF;
        endcase
        // only decoded shadow addresses in the window take writes
        shadow_wr = reg_wr && reg_addr >= APR_SHADOW_LO && reg_addr <= APR_SHADOW_HI
                    && slot_of(reg_addr) != 3'd7;
    end

    apr_regfile u_rf (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr_en   (shadow_wr),
        .wr_idx  (slot_of(reg_addr)),
        .wr_data (reg_wdata & wmask),
        .commit  (commit_q),
        .rd_idx  (slot_of(reg_addr)),
        .rd_data (rf_rdata),
        .active  (active)
    );

    assign modes_active = active[7:0];
    assign clkdiv_act   = active[15:8];
    assign test_act     = active[23:16];
    assign bist_act     = active[31:24];
    assign offs_act     = active[39:32];

    // transfer bit pulses one cycle then clears itself
    always_comb begin
        commit_d    = reg_wr && reg_addr == APR_ADDR_COMMIT
                      && reg_wdata[APR_COMMIT_BIT];
        rd_commit_d = reg_rd && reg_addr == APR_ADDR_COMMIT;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            commit_q    <= 1'b0;
            rd_commit_q <= 1'b0;
        end else begin
            commit_q    <= commit_d;
            rd_commit_q <= rd_commit_d;
        end
    end
    // transfer always reads back as zero since it autoclears
    assign reg_rdata = rd_commit_q ? APR_RST_VAL : rf_rdata;

    // clock divider: one pulse every field+1 clocks
    logic [2:0] div_cnt_q, div_cnt_d;
    logic       div_pulse_d;
    always_comb begin
        div_pulse_d = (div_cnt_q >= clkdiv_act[APR_CLKDIV_MSB:0]);
        div_cnt_d   = div_pulse_d ? 3'd0 : div_cnt_q + 3'd1;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt_q     <= 3'd0;
            clk_div_pulse <= 1'b0;
        end else begin
            div_cnt_q     <= div_cnt_d;
            clk_div_pulse <= div_pulse_d;
        end
    end

    // self-test start: rising edge of the active enable bit
    // edge, not level, so a repeated transfer does not restart it
    always_comb begin
        bist_en_d    = bist_act[APR_BIST_EN_BIT];
        bist_start_d = bist_en_d && !bist_en_q;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bist_en_q  <= 1'b0;
            bist_start <= 1'b0;
        end else begin
            bist_en_q  <= bist_en_d;
            bist_start <= bist_start_d;
        end
    end

    // pattern generators; PN lfsrs free-run so sequences keep going
    logic [22:0] pn23_q, pn23_d;
    logic [8:0]  pn9_q, pn9_d;
    logic        tog_q, tog_d;
    logic [APR_SW-1:0] pat, samp_trim, out_d;
    logic signed [APR_SW+1:0] sum;
    always_comb begin
        pn23_d = {pn23_q[21:0], pn23_q[22] ^ pn23_q[17]};
        pn9_d  = {pn9_q[7:0], pn9_q[8] ^ pn9_q[4]};
        tog_d  = !tog_q;
        case (apr_tp_type'(test_act[APR_TEST_MSB:0]))
            APR_TP_MID:     pat = APR_MID;
            APR_TP_POSFS:   pat = APR_POS_FS;
            APR_TP_NEGFS:   pat = APR_NEG_FS;
            APR_TP_CHECK:   pat = tog_q ? ~APR_CHECKER : APR_CHECKER;
            APR_TP_PNLONG:  pat = pn23_q[APR_SW-1:0];
            APR_TP_PNSHORT: pat = {pn9_q, pn9_q[4:0]};
            APR_TP_WTOG:    pat = tog_q ? APR_POS_FS : APR_NEG_FS;
            APR_TP_USER:    pat = user_pattern;
            APR_TP_BTOG:    pat = tog_q ? APR_CHECKER : ~APR_CHECKER;
            APR_TP_SYNC:    pat = APR_SYNC_WORD;
            APR_TP_ONEBIT:  pat = APR_ONE_HIGH;
            default:        pat = APR_NEG_FS;
        endcase
        // twos complement trim, saturated to the code range
        sum = $signed({2'b00, adc_sample}) + $signed({{8{offs_act[7]}}, offs_act});
        if (sum < 0) begin
            samp_trim = APR_NEG_FS;
        end else if (sum > $signed({2'b00, APR_POS_FS})) begin
            samp_trim = APR_POS_FS;
        end else begin
            samp_trim = sum[APR_SW-1:0];
        end
        out_d = (test_act[APR_TEST_MSB:0] != 4'h0) ? pat : samp_trim;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pn23_q   <= APR_PN23_SEED;
            pn9_q    <= APR_PN9_SEED;
            tog_q    <= 1'b0;
            data_out <= APR_NEG_FS;
        end else begin
            pn23_q   <= pn23_d;
            pn9_q    <= pn9_d;
            tog_q    <= tog_d;
            data_out <= out_d;
        end
    end

    a_commit_copies: assert property (@(posedge clk) disable iff (sys_rst)
        commit_q |=> active == {$past(u_rf.shadow_q[4]), $past(u_rf.shadow_q[3]),
                                $past(u_rf.shadow_q[2]), $past(u_rf.shadow_q[1]),
                                $past(u_rf.shadow_q[0])})
        else $error("commit did not copy");
    a_hold_no_commit: assert property (@(posedge clk) disable iff (sys_rst)
        !commit_q |=> $stable(active))
        else $error("active changed without transfer");
    a_commit_clears: assert property (@(posedge clk) disable iff (sys_rst)
        commit_q && !(reg_wr && reg_addr == APR_ADDR_COMMIT) |=> !commit_q)
        else $error("transfer did not clear");
    a_rd_transfer: assert property (@(posedge clk) disable iff (sys_rst)
        reg_rd && reg_addr == APR_ADDR_COMMIT |=> reg_rdata == APR_RST_VAL)
        else $error("transfer register read nonzero");
    a_div_one: assert property (@(posedge clk) disable iff (sys_rst)
        clkdiv_act[2:0] == 3'd0 |=> clk_div_pulse)
        else $error("divide by one missed a pulse");
    a_div_period: assert property (@(posedge clk) disable iff (sys_rst)
        clkdiv_act == 8'h00 && $past(clkdiv_act) == 8'h00 |-> div_cnt_q == 3'd0)
        else $error("divide by one not held");
    a_test_out: assert property (@(posedge clk) disable iff (sys_rst)
        test_act[3:0] == 4'h2 ##1 $stable(test_act) |-> data_out == APR_POS_FS)
        else $error("test word not driven");
    a_trim_zero: assert property (@(posedge clk) disable iff (sys_rst)
        test_act == 8'h00 && offs_act == 8'h00 |=> data_out == $past(adc_sample))
        else $error("zero trim altered sample");
    a_mid_code: assert property (@(posedge clk) disable iff (sys_rst)
        test_act[3:0] == 4'h1 |=> data_out == APR_MID || $changed(test_act))
        else $error("midscale pattern wrong");
    a_bist_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        bist_start |=> !bist_start)
        else $error("self-test start not a pulse");
    c_commit: cover property (@(posedge clk) disable iff (sys_rst) commit_q);
    c_pattern: cover property (@(posedge clk) disable iff (sys_rst) test_act[3:0] == 4'h5);
    c_divide: cover property (@(posedge clk) disable iff (sys_rst) clkdiv_act[2:0] == 3'd3);
    c_bist: cover property (@(posedge clk) disable iff (sys_rst) bist_start);
    c_reserved: cover property (@(posedge clk) disable iff (sys_rst) test_act[3:0] == 4'hC);
endmodule : apr_bank
`default_nettype wire

// File: shared/apr_pkg.sv
/*
 Program register bank constants: register addresses, field positions,
 reset values, test pattern codes and divider settings.
 Assumes a byte-wide serial control port with 8-bit addresses.
*/
`default_nettype none
package apr_pkg;
    localparam int         APR_AW            = 8;
    localparam int         APR_DW            = 8;
    localparam int         APR_SW            = 14;
    localparam logic [7:0] APR_ADDR_MODES    = 8'h08;
    localparam logic [7:0] APR_ADDR_CLKDIV   = 8'h0B;
    localparam logic [7:0] APR_ADDR_TEST     = 8'h0D;
    localparam logic [7:0] APR_ADDR_BIST     = 8'h0E;
    localparam logic [7:0] APR_ADDR_OFFSET   = 8'h10;
    localparam logic [7:0] APR_ADDR_COMMIT   = 8'hFF;
    localparam logic [7:0] APR_SHADOW_LO     = 8'h08;
    localparam logic [7:0] APR_SHADOW_HI     = 8'h18;
    localparam logic [7:0] APR_RST_VAL       = 8'h00;
    localparam int         APR_COMMIT_BIT    = 0;
    localparam int         APR_BIST_EN_BIT   = 0;
    localparam int         APR_CLKDIV_MSB    = 2;
    localparam int         APR_TEST_MSB      = 3;
    localparam logic [7:0] APR_BIST_MASK     = 8'h05;
    localparam logic [7:0] APR_CLKDIV_MASK   = 8'h07;
    localparam logic [13:0] APR_MID          = 14'h2000;
    localparam logic [13:0] APR_POS_FS       = 14'h3FFF;
    localparam logic [13:0] APR_NEG_FS       = 14'h0000;
    localparam logic [13:0] APR_CHECKER      = 14'h2AAA;
    localparam logic [13:0] APR_ONE_HIGH     = 14'h2000;
    localparam logic [13:0] APR_SYNC_WORD    = 14'h0001;
    localparam logic [22:0] APR_PN23_SEED    = 23'h7FFFFF;
    localparam logic [8:0]  APR_PN9_SEED     = 9'h1FF;
    typedef enum logic [3:0] {
        APR_TP_OFF     = 4'h0,
        APR_TP_MID     = 4'h1,
        APR_TP_POSFS   = 4'h2,
        APR_TP_NEGFS   = 4'h3,
        APR_TP_CHECK   = 4'h4,
        APR_TP_PNLONG  = 4'h5,
        APR_TP_PNSHORT = 4'h6,
        APR_TP_WTOG    = 4'h7,
        APR_TP_USER    = 4'h8,
        APR_TP_BTOG    = 4'h9,
        APR_TP_SYNC    = 4'hA,
        APR_TP_ONEBIT  = 4'hB
    } apr_tp_type;
endpackage : apr_pkg
`default_nettype wire

// File: rtl/apr_regfile.sv
/*
 Shadow and active register pair store for the five program registers.
 Assumes write strobes come from the same clock domain as clk.
*/
`timescale 1ns/1ps
`default_nettype none
module apr_regfile
    import apr_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             wr_en,
    input  wire logic [2:0]       wr_idx,
    input  wire logic [7:0]       wr_data,
    input  wire logic             commit,
    input  wire logic [2:0]       rd_idx,
    output var  logic [7:0]       rd_data,
    output var  logic [5*8-1:0]   active
);
    logic [7:0] shadow_q [5];
    logic [7:0] shadow_d [5];
    logic [7:0] active_q [5];
    logic [7:0] active_d [5];
    logic [7:0] rd_d;

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_reg
            always_comb begin
                shadow_d[g] = shadow_q[g];
                if (wr_en && wr_idx == 3'(g)) begin
                    shadow_d[g] = wr_data;
                end
                // one edge moves all five at once
                active_d[g] = commit ? shadow_q[g] : active_q[g];
            end
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    shadow_q[g] <= APR_RST_VAL;
                    active_q[g] <= APR_RST_VAL;
                end else begin
                    shadow_q[g] <= shadow_d[g];
                    active_q[g] <= active_d[g];
                end
            end
            assign active[g*8 +: 8] = active_q[g];
        end
    endgenerate

    always_comb begin
        rd_d = (rd_idx < 3'd5) ? shadow_q[rd_idx] : APR_RST_VAL;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= APR_RST_VAL;
        end else begin
            rd_data <= rd_d;
        end
    end
endmodule : apr_regfile
`default_nettype wire

// File: sim/apr_host.sv
/*
 Serial control host model: issues single-cycle register writes and
 reads and the transfer command on the register strobes.
 Assumes the bank takes strobes on the rising edge of clk and answers
 a read one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module apr_host
    import apr_pkg::*;
(
    input  wire logic              clk,
    output var  logic              reg_wr,
    output var  logic              reg_rd,
    output var  logic [APR_AW-1:0] reg_addr,
    output var  logic [APR_DW-1:0] reg_wdata,
    input  wire logic [APR_DW-1:0] reg_rdata
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    // released lines show the inverse, so a stale value never passes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_rd   = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1;
        reg_rd   = 1'b0;
        d        = reg_rdata;
        reg_addr = ~a;
    endtask : rd
    // transfer command, then wait out the two-stage update and output register
    task automatic commit();
        wr(APR_ADDR_COMMIT, 8'h01);
        repeat (3) @(posedge clk);
        #1;
    endtask : commit
endmodule : apr_host
`default_nettype wire

// File: sim/adc_program_register_bank_tb_top.sv
/*
 Self-checking bench for the program register bank: reset values,
 shadow and transfer, test patterns, offset trim, divider, self-test.
 Assumes apr_host drives the register strobes; the bench drives samples.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_program_register_bank_tb_top;
    import apr_pkg::*;
    logic              clk;
    logic              sys_rst;
    logic              reg_wr;
    logic              reg_rd;
    logic [APR_AW-1:0] reg_addr;
    logic [APR_DW-1:0] reg_wdata;
    logic [APR_DW-1:0] reg_rdata;
    logic [APR_SW-1:0] adc_sample;
    logic [APR_SW-1:0] user_pattern;
    logic [APR_SW-1:0] data_out;
    logic              clk_div_pulse;
    logic [7:0]        modes_active;
    logic              bist_start;
    int                n_errors;
    int                n_compared;
    int                n_bist = 0;
    logic [7:0]        rv;

    apr_bank dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .adc_sample(adc_sample), .user_pattern(user_pattern), .data_out(data_out),
        .clk_div_pulse(clk_div_pulse), .modes_active(modes_active), .bist_start(bist_start));
    apr_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    initial clk = 1'b0;
    always #4 clk = ~clk;
    always @(posedge clk) if (bist_start === 1'b1) n_bist++;

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_word(input logic [13:0] got, input logic [13:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_not(input logic [13:0] got, input logic [13:0] bad);
        n_compared++;
        if (got === bad || $isunknown(got)) begin
            n_errors++;
            $display("MISMATCH t=%0t word %h still shows the sample", $time, got);
        end
    endtask : chk_not
    task automatic set_sample(input logic [13:0] s);
        @(posedge clk);
        #1;
        adc_sample = s;
        repeat (2) @(posedge clk);
        #1;
    endtask : set_sample
    task automatic t_reset();
        logic [7:0] a [7] = '{8'h08, 8'h0B, 8'h0D, 8'h0E, 8'h10, 8'hFF, 8'h13};
        foreach (a[i]) begin
            host.rd(a[i], rv);
            chk_byte(rv, 8'h00);
        end
        set_sample(14'h1234);
        chk_word(data_out, 14'h1234);
        chk_byte(modes_active, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_shadow();
        host.wr(APR_ADDR_MODES, 8'hA5);
        host.wr(APR_ADDR_TEST, 8'h02);
        repeat (4) @(posedge clk);
        #1;
        chk_byte(modes_active, 8'h00);
        chk_word(data_out, 14'h1234);
        host.rd(APR_ADDR_MODES, rv);
        chk_byte(rv, 8'hA5);
        host.commit();
        chk_byte(modes_active, 8'hA5);
        chk_word(data_out, 14'h3FFF);
        host.rd(APR_ADDR_COMMIT, rv);
        chk_byte(rv, 8'h00);
        $display("test shadow done");
    endtask : t_shadow
    task automatic t_patterns();
        logic [3:0]  c [7] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'hA, 4'hB, 4'hC};
        logic [13:0] e [7] = '{APR_MID, APR_POS_FS, APR_NEG_FS, 14'h0C3A, APR_SYNC_WORD,
                               APR_ONE_HIGH, APR_NEG_FS};
        logic [3:0]  v [5] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h9};
        logic [13:0] w;
        user_pattern = 14'h0C3A;
        foreach (c[i]) begin
            host.wr(APR_ADDR_TEST, {4'h0, c[i]});
            host.commit();
            chk_word(data_out, e[i]);
        end
        foreach (v[i]) begin
            host.wr(APR_ADDR_TEST, {4'h0, v[i]});
            host.commit();
            w = data_out;
            chk_not(w, 14'h1234);
            // toggling patterns must flip every word
            if (v[i] inside {4'h4, 4'h7, 4'h9}) begin
                @(posedge clk);
                #1;
                chk_word(data_out, ~w);
            end
        end
        host.wr(APR_ADDR_TEST, 8'h00);
        host.commit();
        chk_word(data_out, 14'h1234);
        $display("test patterns done");
    endtask : t_patterns
    task automatic t_offset();
        logic [7:0]  o [4] = '{8'h7F, 8'h80, 8'h7F, 8'h80};
        logic [13:0] s [4] = '{14'h1000, 14'h1000, 14'h3FF0, 14'h0010};
        logic [13:0] e [4] = '{14'h107F, 14'h0F80, 14'h3FFF, 14'h0000};
        foreach (o[i]) begin
            host.wr(APR_ADDR_OFFSET, o[i]);
            host.commit();
            set_sample(s[i]);
            chk_word(data_out, e[i]);
        end
        $display("test offset done");
    endtask : t_offset
    task automatic t_clkdiv();
        int n;
        host.wr(APR_ADDR_CLKDIV, 8'hFF);
        host.rd(APR_ADDR_CLKDIV, rv);
        chk_byte(rv, APR_CLKDIV_MASK);
        for (int d = 2; d >= 0; d--) begin
            host.wr(APR_ADDR_CLKDIV, d[7:0]);
            host.commit();
            n = 0;
            repeat (12) begin
                @(posedge clk);
                #1;
                if (clk_div_pulse === 1'b1) n++;
            end
            chk_byte(n[7:0], 8'(12 / (d + 1)));
        end
        $display("test clkdiv done");
    endtask : t_clkdiv
    task automatic t_bist();
        int base;
        base = n_bist;
        host.wr(APR_ADDR_BIST, 8'hFF);
        host.rd(APR_ADDR_BIST, rv);
        chk_byte(rv, APR_BIST_MASK);
        host.wr(APR_ADDR_BIST, 8'h01);
        repeat (4) @(posedge clk);
        #1;
        chk_byte(8'(n_bist - base), 8'h00);
        host.commit();
        repeat (3) @(posedge clk);
        #1;
        host.commit();
        chk_byte(8'(n_bist - base), 8'h01);
        $display("test bist done");
    endtask : t_bist
    task automatic t_rerst();
        @(posedge clk);
        #1;
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        chk_byte(modes_active, 8'h00);
        host.rd(APR_ADDR_MODES, rv);
        chk_byte(rv, 8'h00);
        set_sample(14'h0ABC);
        chk_word(data_out, 14'h0ABC);
        $display("test rerst done");
    endtask : t_rerst
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("MISMATCH t=%0t run did not finish", $time);
        end_sim();
    end
    initial begin
        n_errors     = 0;
        n_compared   = 0;
        sys_rst      = 1'b1;
        adc_sample   = 14'h0000;
        user_pattern = 14'h0000;
        repeat (5) @(posedge clk);
        #1;
        chk_word(data_out, 14'h0000);
        sys_rst = 1'b0;
        t_reset();
        t_shadow();
        t_patterns();
        t_offset();
        t_clkdiv();
        t_bist();
        t_rerst();
        end_sim();
    end
endmodule : adc_program_register_bank_tb_top
`default_nettype wire
